/* logic/dmr_params.svh */
// offsets, field positions, reset values and counts of the mode register block
`ifndef DMR_PARAMS_SVH
`define DMR_PARAMS_SVH
`define DMR_OFS_MR      8'h00
`define DMR_OFS_EMR1    8'h04
`define DMR_OFS_EMR2    8'h08
`define DMR_OFS_EMR3    8'h0c
`define DMR_OFS_STATUS  8'h10
`define DMR_OFS_CTRL    8'h14
`define DMR_OFS_FLAGS   8'h18
`define DMR_CTRL_RESET  8'h01
`define DMR_BL_FOUR     3'h2
`define DMR_BL_EIGHT    3'h3
`define DMR_CL_MIN      3'h2
`define DMR_CL_MAX      3'h6
`define DMR_BIT_DLLRST  8
`define DMR_BIT_TEST    7
`define DMR_BIT_DLLDIS  0
`define DMR_BIT_DRV     1
`define DMR_BIT_DQSNDIS 10
`define DMR_BIT_REDUNDANT_READ_STROBE    11
`define DMR_BIT_FASTSR  7
`define DMR_LOCK_CYC    8'd200
`define DMR_RESP_OKAY   2'h0
`define DMR_RESP_SLVERR 2'h2
`endif

/* logic/dmr_pkg.sv */
// types shared by the mode register block
package dmr_pkg;
    typedef struct packed {
        logic        csN;
        logic        rasN;
        logic        casN;
        logic        weN;
        logic [2:0]  ba;
        logic [13:0] addr;
    } dmr_cmd_t;
    typedef struct packed {
        logic        blEight;
        logic        interleave;
        logic [2:0]  casLat;
        logic        testMode;
        logic [2:0]  writeRec;
        logic        drvReduced;
        logic [1:0]  termSel;
        logic [2:0]  addLat;
        logic        dqsNDisable;
        logic        rdqsEn;
        logic        fastSelfRef;
    } dmr_cfg_t;
    typedef enum logic [2:0] {CAL_EXIT, CAL_HIGH, CAL_LOW, CAL_ADJUST, CAL_DEFAULT} dmr_cal_t;
    typedef enum logic [1:0] {DLL_OFF, DLL_IDLE, DLL_LOCKING, DLL_LOCKED} dmr_dll_t;
endpackage : dmr_pkg

/* logic/dmr_mode_regs.sv */
// mode and extended mode registers with dll and driver calibration control
`timescale 1ns/10ps
`include "dmr_params.svh"
module dmr_mode_regs (
    input  wire logic              clk_sys,     // 10 MHz system clock
    input  wire logic              reset_n,     // synchronous reset
    input  wire logic              clkEn,       // freezes all state when low
    input  wire logic              cke,         // memory clock enable pin
    input  wire dmr_pkg::dmr_cmd_t cmd,         // command and address pins
    output dmr_pkg::dmr_cfg_t      cfg,         // decoded operating fields
    output logic                   dllOn,       // dll enabled
    output logic                   dllLocked,   // lock wait elapsed
    output logic                   dmEnable,    // data mask usable
    output logic [7:0]             dqOut,       // data drive value
    output logic                   dqOeN,       // data drive enable
    output logic                   dqsOut,      // true strobe value
    output logic                   dqsNOut,     // complement strobe value
    output logic                   dqsOeN,      // strobe drive enable
    input  wire logic              awvalid,     // axi write address
    output logic                   awready,     // axi
    input  wire logic [7:0]        awaddr,      // axi
    input  wire logic              wvalid,      // axi write data
    output logic                   wready,      // axi
    input  wire logic [31:0]       wdata,       // axi
    input  wire logic [3:0]        wstrb,       // axi
    output logic                   bvalid,      // axi write response
    input  wire logic              bready,      // axi
    output logic [1:0]             bresp,       // axi
    input  wire logic              arvalid,     // axi read address
    output logic                   arready,     // axi
    input  wire logic [7:0]        araddr,      // axi
    output logic                   rvalid,      // axi read data
    input  wire logic              rready,      // axi
    output logic [31:0]            rdata,       // axi
    output logic [1:0]             rresp        // axi
);
    import dmr_pkg::*;

    logic [13:0] mr, emr1, emr2, emr3;
    logic [7:0]  ctrl;
    logic [2:0]  flags;
    dmr_cal_t    calMode;
    dmr_dll_t    dllState;
    logic [7:0]  lockCnt;
    logic        selfRef;
    logic        ckePrev;
    logic        awHeld, wHeld;
    logic [7:0]  awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0]  wStrbQ;

    // command decode; bank bit 2 must be low for every mode set
    // mode set pattern
    logic msCmd, msMr, msE1, msE2, msE3, srEnter, srExit, dllReset;
    assign msCmd = clkEn && cke && ctrl[0] && !cmd.csN && !cmd.rasN
                   && !cmd.casN && !cmd.weN && !cmd.ba[2];
    assign msMr = msCmd && cmd.ba[1:0] == 2'h0;
    assign msE1 = msCmd && cmd.ba[1:0] == 2'h1;
    assign msE2 = msCmd && cmd.ba[1:0] == 2'h2;
    assign msE3 = msCmd && cmd.ba[1:0] == 2'h3;
    // self refresh is a refresh command with clock enable falling
    assign srEnter = clkEn && ckePrev && !cke && !selfRef && !cmd.csN
                     && !cmd.rasN && !cmd.casN && cmd.weN;
    assign srExit = clkEn && selfRef && cke;
    assign dllReset = (msMr && cmd.addr[`DMR_BIT_DLLRST]) || srExit;

    // raw register images, kept whole for read back
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            mr   <= 14'h0000;
            emr1 <= 14'h0000;
            emr2 <= 14'h0000;
            emr3 <= 14'h0000;
        end else begin
            if (msMr) mr <= cmd.addr;
            if (msE1) emr1 <= cmd.addr;
            if (msE2) emr2 <= cmd.addr;
            if (msE3) emr3 <= cmd.addr;
        end
    end

    // decoded fields; unsupported burst codes still load so software sees them
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cfg <= '0;
        end else begin
            if (msMr) begin
                cfg.blEight    <= cmd.addr[2:0] == `DMR_BL_EIGHT;
                cfg.interleave <= cmd.addr[3];
                cfg.casLat     <= cmd.addr[6:4];
                cfg.testMode   <= cmd.addr[`DMR_BIT_TEST];
                cfg.writeRec   <= cmd.addr[11:9];
            end
            if (msE1) begin
                cfg.drvReduced  <= cmd.addr[`DMR_BIT_DRV];
                cfg.termSel     <= {cmd.addr[6], cmd.addr[2]};
                cfg.addLat      <= cmd.addr[5:3];
                cfg.dqsNDisable <= cmd.addr[`DMR_BIT_DQSNDIS];
                cfg.rdqsEn      <= cmd.addr[`DMR_BIT_REDUNDANT_READ_STROBE];
            end
            if (msE2) cfg.fastSelfRef <= cmd.addr[`DMR_BIT_FASTSR];
        end
    end

    // mask off while redundant strobe on
    always_ff @(posedge clk_sys) begin
        if (!reset_n) dmEnable <= 1'b1;
        else if (msE1) dmEnable <= !cmd.addr[`DMR_BIT_REDUNDANT_READ_STROBE];
    end

    // self refresh tracking from the clock enable pin
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            selfRef <= 1'b0;
            ckePrev <= 1'b0;
        end else if (clkEn) begin
            ckePrev <= cke;
            if (srEnter) selfRef <= 1'b1;
            else if (srExit) selfRef <= 1'b0;
        end
    end

    // dll state; an enable write alone does not lock, a reset is needed
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            dllState <= DLL_OFF;
            lockCnt  <= 8'h00;
        end else if (clkEn) begin
            case (dllState)
                DLL_OFF: begin
                    if (msE1 && !cmd.addr[`DMR_BIT_DLLDIS]) dllState <= DLL_IDLE;
                    if (srExit) begin
                        dllState <= DLL_LOCKING;
                        lockCnt  <= 8'h00;
                    end
                end
                DLL_IDLE, DLL_LOCKING, DLL_LOCKED: begin
                    if (dllState == DLL_LOCKING) begin
                        lockCnt <= lockCnt + 8'h01;
                        if (lockCnt == `DMR_LOCK_CYC - 8'd1) dllState <= DLL_LOCKED;
                    end
                    if (dllReset) begin
                        dllState <= DLL_LOCKING;
                        lockCnt  <= 8'h00;
                    end
                    if (srEnter || (msE1 && cmd.addr[`DMR_BIT_DLLDIS])) dllState <= DLL_OFF;
                end
                default: dllState <= DLL_OFF;
            endcase
        end
    end

    // registered dll outputs follow the state
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            dllOn     <= 1'b0;
            dllLocked <= 1'b0;
        end else if (clkEn) begin
            dllOn     <= dllState != DLL_OFF;
            dllLocked <= dllState == DLL_LOCKED;
        end
    end

    // calibration code decode; reserved codes keep the current mode
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            calMode <= CAL_EXIT;
        end else if (msE1) begin
            case (cmd.addr[9:7])
                3'h0: calMode <= CAL_EXIT;
                3'h1: calMode <= CAL_HIGH;
                3'h2: calMode <= CAL_LOW;
                3'h4: calMode <= CAL_ADJUST;
                3'h7: calMode <= CAL_DEFAULT;
                default: calMode <= calMode;
            endcase
        end
    end

    // forced pin levels; enables are low while driving
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            dqOut   <= 8'h00;
            dqOeN   <= 1'b1;
            dqsOut  <= 1'b0;
            dqsNOut <= 1'b1;
            dqsOeN  <= 1'b1;
        end else if (clkEn) begin
            dqOut   <= {8{calMode == CAL_HIGH}};
            dqsOut  <= calMode == CAL_HIGH;
            dqsNOut <= calMode != CAL_HIGH;
            dqOeN   <= !(calMode == CAL_HIGH || calMode == CAL_LOW);
            dqsOeN  <= !(calMode == CAL_HIGH || calMode == CAL_LOW);
        end
    end

    // sticky error flags, set wins over a software clear
    logic [2:0] flagSet, flagClr;
    assign flagSet = {msCmd == 1'b0 && clkEn && cke && !ctrl[0] && !cmd.csN
                      && !cmd.rasN && !cmd.casN && !cmd.weN,
                      msMr && (cmd.addr[6:4] < `DMR_CL_MIN || cmd.addr[6:4] > `DMR_CL_MAX),
                      msMr && cmd.addr[2:0] != `DMR_BL_FOUR
                           && cmd.addr[2:0] != `DMR_BL_EIGHT};
    assign flagClr = (bvalid == 1'b0 && awHeld && wHeld && awAddrQ == `DMR_OFS_FLAGS
                      && wStrbQ[0]) ? wDataQ[2:0] : 3'h0;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) flags <= 3'h0;
        else if (clkEn) flags <= flagSet | (flags & ~flagClr);
    end

    // axi write: address and data taken in either order, answer once both held
    logic wrGo, wrMapped;
    assign wrGo = clkEn && awHeld && wHeld && !bvalid;
    assign wrMapped = awAddrQ <= `DMR_OFS_FLAGS && awAddrQ[1:0] == 2'h0;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= `DMR_RESP_OKAY;
            awAddrQ <= 8'h00;
            wDataQ  <= 32'h0000_0000;
            wStrbQ  <= 4'h0;
        end else if (clkEn) begin
            if (awvalid && awready) begin
                awHeld  <= 1'b1;
                awready <= 1'b0;
                awAddrQ <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld  <= 1'b1;
                wready <= 1'b0;
                wDataQ <= wdata;
                wStrbQ <= wstrb;
            end
            if (wrGo) begin
                bvalid <= 1'b1;
                bresp  <= wrMapped ? `DMR_RESP_OKAY : `DMR_RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awHeld  <= 1'b0;
                wHeld   <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // control register; bit 0 lets mode set commands through
    always_ff @(posedge clk_sys) begin
        if (!reset_n) ctrl <= `DMR_CTRL_RESET;
        else if (wrGo && awAddrQ == `DMR_OFS_CTRL && wStrbQ[0]) ctrl <= wDataQ[7:0];
    end

    // axi read: one cycle from address to data
    logic [31:0] rdMux;
    logic        rdHit;
    always_comb begin
        rdHit = 1'b1;
        case (araddr)
            `DMR_OFS_MR:     rdMux = {18'h0, mr};
            `DMR_OFS_EMR1:   rdMux = {18'h0, emr1};
            `DMR_OFS_EMR2:   rdMux = {18'h0, emr2};
            `DMR_OFS_EMR3:   rdMux = {18'h0, emr3};
            `DMR_OFS_STATUS: rdMux = {25'h0, selfRef, calMode, dllState, dllLocked};
            `DMR_OFS_CTRL:   rdMux = {24'h0, ctrl};
            `DMR_OFS_FLAGS:  rdMux = {29'h0, flags};
            default: begin
                rdMux = 32'h0000_0000;
                rdHit = 1'b0;
            end
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `DMR_RESP_OKAY;
        end else if (clkEn) begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= rdMux;
                rresp   <= rdHit ? `DMR_RESP_OKAY : `DMR_RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_mr_load;
        msMr |=> mr == $past(cmd.addr);
    endproperty
    a_mr_load: assert property (p_mr_load) else $error("main register not loaded");
    property p_e1_load;
        msE1 |=> emr1 == $past(cmd.addr);
    endproperty
    a_e1_load: assert property (p_e1_load) else $error("ext one not loaded");
    property p_burst;
        msMr && cmd.addr[2:0] == `DMR_BL_EIGHT |=> cfg.blEight;
    endproperty
    a_burst: assert property (p_burst) else $error("burst eight not decoded");
    property p_badburst;
        msMr && cmd.addr[2:0] == 3'h1 |=> flags[0];
    endproperty
    a_badburst: assert property (p_badburst) else $error("bad burst not flagged");
    property p_lat;
        msMr |=> cfg.casLat == $past(cmd.addr[6:4]) && cfg.interleave == $past(cmd.addr[3]);
    endproperty
    a_lat: assert property (p_lat) else $error("latency or type wrong");
    property p_dllrst;
        msMr && cmd.addr[8] && dllState != DLL_OFF |=> dllState == DLL_LOCKING ##1 !dllLocked;
    endproperty
    a_dllrst: assert property (p_dllrst) else $error("dll reset ignored");
    property p_srenter;
        srEnter |=> ##1 !dllOn;
    endproperty
    a_srenter: assert property (p_srenter) else $error("dll on in self refresh");
    property p_dlldis;
        msE1 && cmd.addr[0] && !srExit |=> ##1 !dllOn;
    endproperty
    a_dlldis: assert property (p_dlldis) else $error("dll not disabled");
    property p_drvhi;
        msE1 && cmd.addr[9:7] == 3'h1 |=> calMode == CAL_HIGH;
    endproperty
    a_drvhi: assert property (p_drvhi) else $error("drive high not selected");
    property p_pins;
        clkEn && calMode == CAL_LOW |=> !dqOeN && dqOut == 8'h00 && !dqsOut && dqsNOut;
    endproperty
    a_pins: assert property (p_pins) else $error("drive low levels wrong");
    property p_dm;
        msE1 |=> dmEnable == !$past(cmd.addr[11]);
    endproperty
    a_dm: assert property (p_dm) else $error("mask not tied to strobe");
    c_mr: cover property (msMr);
    c_srexit: cover property (srExit);
    c_locked: cover property ($rose(dllLocked));
    c_drive: cover property (!dqOeN);
endmodule : dmr_mode_regs

/* testbench/dmr_ctrl_model.sv */
// controller-side model driving mode set traffic on the command pins
`timescale 1ns/10ps
module dmr_ctrl_model
    import dmr_pkg::*;
#(
    parameter int GAP = 3 // deselect clocks after each command; the command cycle time is one more
) (
    input  wire logic clk_sys, // system clock
    output dmr_cmd_t  cmd,     // command and address pins
    output logic      cke      // memory clock enable
);
    // pins start deselected, clock enable already high
    initial begin
        cmd = '1;
        cke = 1'b1;
    end

    // deselect; address toggles so a stale value never looks like data
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            cmd <= {4'hf, ~cmd.ba, ~cmd.addr};
        end
    endtask : idle

    // one mode set, bank bits pick the register
    task automatic mode_set(input logic [1:0] sel, input logic [13:0] a);
        @(posedge clk_sys);
        cke <= 1'b1;
        cmd <= {4'h0, 1'b0, sel, a};
        idle(GAP);
    endtask : mode_set

    task automatic sr_enter();
        @(posedge clk_sys);
        cmd <= {4'b0001, cmd.ba, cmd.addr};
        cke <= 1'b0;
        idle(GAP);
    endtask : sr_enter

    // cke back high leaves self refresh
    task automatic sr_exit();
        @(posedge clk_sys);
        cke <= 1'b1;
        idle(GAP);
    endtask : sr_exit
endmodule : dmr_ctrl_model

/* testbench/dmr_mode_regs_bench.sv */
// self-checking bench for the mode register block
`timescale 1ns/10ps
`include "dmr_params.svh"
module dmr_mode_regs_bench;
    import dmr_pkg::*;
    logic        clk_sys = 1'b0, reset_n = 1'b0, clkEn = 1'b1, cke, drv;
    dmr_cmd_t    cmd;
    dmr_cfg_t    cfg;
    logic        dllOn, dllLocked, dmEnable, dqOeN, dqsOut, dqsNOut, dqsOeN;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  dqOut, awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0]  wstrb = 4'h0;
    logic [1:0]  bresp, rresp, rs;
    logic [13:0] word;
    logic [2:0]  bl, cl, al;
    logic [2:0]  codes [4] = '{3'h7, 3'h1, 3'h2, 3'h4};
    integer      seed = 32'h57f3, failures = 0, checks = 0;

    // 10 MHz clock
    always #50 clk_sys = ~clk_sys;

    dmr_ctrl_model #(.GAP(3)) u_dmr_ctrl_model (.clk_sys(clk_sys), .cmd(cmd), .cke(cke));
    dmr_mode_regs u_dmr_mode_regs (
        .clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn), .cke(cke), .cmd(cmd), .cfg(cfg),
        .dllOn(dllOn), .dllLocked(dllLocked), .dmEnable(dmEnable), .dqOut(dqOut),
        .dqOeN(dqOeN), .dqsOut(dqsOut), .dqsNOut(dqsNOut), .dqsOeN(dqsOeN),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
    );

    // expected status field for each calibration code
    function automatic logic [2:0] cal_mode(input logic [2:0] code);
        case (code)
            3'h1: return 3'h1;
            3'h2: return 3'h2;
            3'h4: return 3'h3;
            3'h7: return 3'h4;
            default: return 3'h0;
        endcase
    endfunction : cal_mode

    // comparisons count every call, print only on mismatch
    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val

    task automatic check_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check_resp

    // verdict and end of run
    task automatic stop_test();
        if (failures == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    // write: address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit awDone;
        bit wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge clk_sys);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        while (!(awDone && wDone)) begin
            @(posedge clk_sys);
            if (!awDone && awready === 1'b1) begin
                awDone = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wDone && wready === 1'b1) begin
                wDone = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clk_sys); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    // read: rready held high until the data edge
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge clk_sys); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_sys); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a, rd, rs);
        check_resp(name, `DMR_RESP_OKAY, rs);
        check_val(name, exp, rd);
    endtask : rd_chk

    // watchdog, more than twenty times the expected run length
    initial begin
        #1_000_000;
        failures++;
        stop_test();
    end

    // main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd_chk("ctrl", `DMR_OFS_CTRL, 32'h1);
        rd_chk("flags", `DMR_OFS_FLAGS, 32'h0);
        check_val("idlePins", 32'h7, {29'h0, dmEnable, dqOeN, dqsOeN});
        axi_rd(8'h1c, rd, rs);
        check_resp("unmappedRd", `DMR_RESP_SLVERR, rs);
        axi_wr(8'h40, 32'h0, rs);
        check_resp("unmappedWr", `DMR_RESP_SLVERR, rs);
        // initialization order: register two, three, then one
        u_dmr_ctrl_model.mode_set(2'd2, 14'h0080);
        check_val("fastSelfRef", 32'h1, {31'h0, cfg.fastSelfRef});
        rd_chk("emr2", `DMR_OFS_EMR2, 32'h80);
        u_dmr_ctrl_model.mode_set(2'd3, 14'h0000);
        al = 3'($unsigned($random(seed)) % 7);
        cl = 3'($random(seed));
        word = {4'b0011, 3'b000, cl[1], al, cl[0], 2'b10};
        u_dmr_ctrl_model.mode_set(2'd1, word);
        check_val("emr1Fields", {23'h0, cl[1:0], al, 4'hf},
            {23'h0, cfg.termSel, cfg.addLat, cfg.drvReduced, cfg.dqsNDisable, cfg.rdqsEn,
             dllOn});
        check_val("dmEnable", 32'h0, {31'h0, dmEnable});
        rd_chk("emr1", `DMR_OFS_EMR1, {18'h0, word});
        // dll reset, then the lock wait
        u_dmr_ctrl_model.mode_set(2'd0, 14'h0142);
        axi_rd(`DMR_OFS_STATUS, rd, rs);
        check_val("locking", 32'h2, {30'h0, rd[2:1]});
        repeat (185) @(posedge clk_sys);
        check_val("notLocked", 32'h0, {31'h0, dllLocked});
        repeat (15) @(posedge clk_sys);
        check_val("locked", 32'h1, {31'h0, dllLocked});
        // random main settings, legal codes only, test bit low
        for (int i = 0; i < 8; i++) begin
            bl = ($random(seed) & 1) ? `DMR_BL_EIGHT : `DMR_BL_FOUR;
            cl = 3'(2 + $unsigned($random(seed)) % 5);
            word = {2'b00, 3'($random(seed)), 2'b00, cl, 1'($random(seed)), bl};
            u_dmr_ctrl_model.mode_set(2'd0, word);
            check_val("mrFields", {23'h0, bl == `DMR_BL_EIGHT, word[3], cl, 1'b0, word[11:9]},
                {23'h0, cfg.blEight, cfg.interleave, cfg.casLat, cfg.testMode,
                 cfg.writeRec});
            rd_chk("mr", `DMR_OFS_MR, {18'h0, word});
        end
        // bad burst and latency codes raise sticky flags
        u_dmr_ctrl_model.mode_set(2'd0, 14'h0021);
        u_dmr_ctrl_model.mode_set(2'd0, 14'h0072);
        rd_chk("flagsSet", `DMR_OFS_FLAGS, 32'h3);
        axi_wr(`DMR_OFS_FLAGS, 32'h1, rs);
        rd_chk("flagsW1c", `DMR_OFS_FLAGS, 32'h2);
        axi_wr(`DMR_OFS_MR, 32'h3fff, rs);
        check_resp("roWr", `DMR_RESP_OKAY, rs);
        rd_chk("mrKept", `DMR_OFS_MR, 32'h72);
        // acceptance off drops the command and flags it
        axi_wr(`DMR_OFS_CTRL, 32'h0, rs);
        axi_wr(`DMR_OFS_FLAGS, 32'h2, rs);
        u_dmr_ctrl_model.mode_set(2'd0, 14'h0032);
        rd_chk("mrGated", `DMR_OFS_MR, 32'h72);
        rd_chk("flagsGate", `DMR_OFS_FLAGS, 32'h4);
        axi_wr(`DMR_OFS_CTRL, 32'h1, rs);
        // frozen clock enable ignores the pins too
        clkEn <= 1'b0;
        u_dmr_ctrl_model.mode_set(2'd0, 14'h0032);
        clkEn <= 1'b1;
        rd_chk("mrFrozen", `DMR_OFS_MR, 32'h72);
        // each calibration step followed by its exit
        foreach (codes[i]) begin
            u_dmr_ctrl_model.mode_set(2'd1, {4'h0, codes[i], 1'b0, al, 3'h0});
            axi_rd(`DMR_OFS_STATUS, rd, rs);
            check_val("calMode", {29'h0, cal_mode(codes[i])}, {29'h0, rd[5:3]});
            drv = (codes[i] == 3'h1) || (codes[i] == 3'h2);
            check_val("outEn", {30'h0, ~drv, ~drv}, {30'h0, dqOeN, dqsOeN});
            if (drv) begin
                check_val("drive", {22'h0, {9{codes[i][0]}}, codes[i][1]},
                    {22'h0, dqOut, dqsOut, dqsNOut});
            end
            u_dmr_ctrl_model.mode_set(2'd1, {8'h0, al, 3'h0});
            check_val("outOff", 32'h3, {30'h0, dqOeN, dqsOeN});
        end
        // self refresh stops the dll, leaving restarts the lock
        u_dmr_ctrl_model.sr_enter();
        axi_rd(`DMR_OFS_STATUS, rd, rs);
        check_val("srIn", 32'h8, {28'h0, rd[6], rd[2:1], dllOn});
        u_dmr_ctrl_model.sr_exit();
        axi_rd(`DMR_OFS_STATUS, rd, rs);
        check_val("srOut", 32'h5, {28'h0, rd[6], rd[2:1], dllOn});
        // ext one A0 high turns the dll off again
        u_dmr_ctrl_model.mode_set(2'd1, {8'h0, al, 3'b001});
        check_val("dllOff", 32'h0, {31'h0, dllOn});
        stop_test();
    end
endmodule : dmr_mode_regs_bench
